/* core/xbc_pkg.sv */
// Package with constants and types for the external bus controller
package xbc_pkg;
    localparam int XBC_ADDR_W      = 24;
    localparam int XBC_DATA_W      = 16;
    localparam int XBC_NUM_WIN     = 4;
    localparam int XBC_NUM_CS      = 4;
    localparam int XBC_SEG_MAX     = 8;
    localparam int XBC_WAIT_W      = 4;
    // Region function config fields
    localparam int FC_MUX_BIT      = 0;
    localparam int FC_WIDE_BIT     = 1;
    localparam int FC_RDY_EN_BIT   = 2;
    localparam int FC_CS_EN_BIT    = 3;
    localparam int FC_W            = 4;
    // Region timing config fields
    localparam int TC_ALE_LSB      = 0;
    localparam int TC_WAIT_LSB     = 4;
    localparam int TC_W            = 8;
    localparam logic [TC_W-1:0] TC_RESET = 8'h1F;
    localparam logic [FC_W-1:0] FC_RESET = 4'h8;
    typedef enum logic [2:0] {
        XBC_IDLE  = 3'b000,
        XBC_ADDR  = 3'b001,
        XBC_WAIT  = 3'b010,
        XBC_READY = 3'b011,
        XBC_DONE  = 3'b100
    } xbc_state_t;
endpackage

/* core/xbc_top.sv */
// External bus controller: window decode, per-region timing, bus cycle sequencer
// How it works
// - SINGLE_CHIP high disables the external bus; otherwise external mode runs.
// - ADDR_BITS selects how many address bits, 0 to 24, are driven.
// - Data width per region is 8 or 16 bits.
// - Demux mode drives low address on its own lines, mux shares AD lines.
// - SEG_LINES chooses active segment lines; unused ones have enable released.
// - Four active-low chip selects: three windows plus default region.
// - Each region has its own timing and function configuration.
// - Ready input stretches accesses; its active polarity is selectable.
// - Four address windows each match a base address and size.
// - Window 4 beats 3, window 2 beats 1.
// - No window match uses default region zero.
// - Selected region's chip select is low during an external access; window 4 has none.
// - Bus signals change on rising edge of the driven reference clock.
// - Width and multiplexing switch per access following the region.
// - Extension bus accesses run through the same sequencer.
// - 24-bit byte address, 256 segments, byte or word access.
`timescale 1ns/10ps
`default_nettype none
module xbc_top
    import xbc_pkg::*;
#(
    parameter int ADDR_W = XBC_ADDR_W,
    parameter int DATA_W = XBC_DATA_W
) (
    input  wire logic                 CLK,
    input  wire logic                 RST_B,
    input  wire logic                 CE,
    input  wire logic                 SINGLE_CHIP,
    input  wire logic [4:0]           ADDR_BITS,
    input  wire logic [3:0]           SEG_LINES,
    input  wire logic                 READY_ACT_HIGH,
    input  wire logic [TC_W-1:0]      DEFAULT_REGION_TIMING_CONFIG,
    input  wire logic [FC_W-1:0]      DEFAULT_REGION_FUNCTION_CONFIG,
    input  wire logic [4*TC_W-1:0]    REGION_TIMING_CONFIG,
    input  wire logic [4*FC_W-1:0]    REGION_FUNCTION_CONFIG,
    input  wire logic [4*16-1:0]      WINDOW_ADDRESS_SELECT,
    input  wire logic                 REQ,
    input  wire logic                 REQ_WRITE,
    input  wire logic                 REQ_WORD,
    input  wire logic                 REQ_ONCHIP,
    input  wire logic [ADDR_W-1:0]    REQ_ADDR,
    input  wire logic [DATA_W-1:0]    REQ_WDATA,
    output logic                      REQ_READY,
    output logic                      RESP_VALID,
    output logic [DATA_W-1:0]         RESP_RDATA,
    output logic                      BUS_REFERENCE_CLOCK_OUT,
    output logic [ADDR_W-1:0]         ADDR_OUT,
    output logic [ADDR_W-1:0]         ADDR_OE_B,
    output logic [DATA_W-1:0]         AD_OUT,
    output logic [DATA_W-1:0]         AD_OE_B,
    input  wire logic [DATA_W-1:0]    AD_IN,
    output logic                      ALE,
    output logic                      RD_B,
    output logic                      WR_B,
    output logic                      BHE_B,
    output logic [XBC_NUM_CS-1:0]     CS_B,
    input  wire logic                 READY_IN,
    output logic                      ONCHIP_SEL,
    output logic                      BUSY
);
    // Field slicing below is written for these widths only
    if (ADDR_W != 24 || DATA_W != 16) begin : g_bad_width
        $error("xbc_top supports a 24-bit address and 16-bit data only");
    end

    // Window select: [7:0] base segment, [11:8] size code (2^n segments), [12] enable
    function automatic logic win_hit(input logic [15:0] sel, input logic [ADDR_W-1:0] a);
        logic [7:0] mask;
        mask = 8'h00;
        mask = 8'hFF << sel[11:8];
        return sel[12] && ((a[23:16] & mask) == (sel[7:0] & mask));
    endfunction

    // Strobe phase covers the programmed wait and any ready stretch
    function automatic logic strobe_phase(input xbc_state_t s);
        return s == XBC_WAIT || s == XBC_READY;
    endfunction

    logic [1:0] rdy_sync_r;
    logic       ready_act;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdy_sync_r <= 2'b00;
        end else if (CE) begin
            rdy_sync_r <= {rdy_sync_r[0], READY_IN};
        end
    end
    assign ready_act = (rdy_sync_r[1] == READY_ACT_HIGH);

    // Data pins pass two stages; a region needs a wait of one or a ready stretch
    logic [DATA_W-1:0] ad_meta_r;
    logic [DATA_W-1:0] ad_sync_r;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ad_meta_r <= '0;
            ad_sync_r <= '0;
        end else if (CE) begin
            ad_meta_r <= AD_IN;
            ad_sync_r <= ad_meta_r;
        end
    end

    // Reference clock: bus changes are launched at its rising edge
    // Half the system clock, so every bus phase lasts a multiple of two cycles
    logic ref_clk_r;
    logic ref_rise;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ref_clk_r <= 1'b0;
        end else if (CE) begin
            ref_clk_r <= ~ref_clk_r;
        end
    end
    assign ref_rise = CE && !ref_clk_r;
    assign BUS_REFERENCE_CLOCK_OUT = ref_clk_r;

    // Highest matching window wins; no match falls back to region 0
    logic [2:0] region;
    logic [XBC_NUM_WIN-1:0] hits;
    genvar gi;
    generate
        for (gi = 0; gi < XBC_NUM_WIN; gi++) begin : g_win
            assign hits[gi] = win_hit(WINDOW_ADDRESS_SELECT[gi*16 +: 16], REQ_ADDR);
        end
    endgenerate
    always_comb begin
        region = 3'd0;
        if (hits[0]) region = 3'd1;
        if (hits[1]) region = 3'd2;
        if (hits[2]) region = 3'd3;
        if (hits[3]) region = 3'd4;
    end

    logic [TC_W-1:0] tc_sel;
    logic [FC_W-1:0] fc_sel;
    always_comb begin
        tc_sel = DEFAULT_REGION_TIMING_CONFIG;
        fc_sel = DEFAULT_REGION_FUNCTION_CONFIG;
        if (region != 3'd0) begin
            tc_sel = REGION_TIMING_CONFIG[(region-3'd1)*TC_W +: TC_W];
            fc_sel = REGION_FUNCTION_CONFIG[(region-3'd1)*FC_W +: FC_W];
        end
    end

    xbc_state_t       state_r;
    logic [XBC_WAIT_W-1:0] cnt_r;
    logic [TC_W-1:0]  tc_r;
    logic [FC_W-1:0]  fc_r;
    logic [2:0]       region_r;
    logic             write_r;
    logic             word_r;
    logic             onchip_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic             take;

    // One access at a time; new requests wait for idle
    assign take = CE && REQ && state_r == XBC_IDLE && !SINGLE_CHIP;
    assign REQ_READY = state_r == XBC_IDLE && !SINGLE_CHIP;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            tc_r <= TC_RESET;
            fc_r <= FC_RESET;
            region_r <= 3'd0;
            write_r <= 1'b0;
            word_r <= 1'b0;
            onchip_r <= 1'b0;
            addr_r <= '0;
            wdata_r <= '0;
        end else if (take) begin
            tc_r <= tc_sel;
            fc_r <= fc_sel;
            region_r <= region;
            write_r <= REQ_WRITE;
            word_r <= REQ_WORD;
            onchip_r <= REQ_ONCHIP;
            addr_r <= REQ_ADDR;
            wdata_r <= REQ_WDATA;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_r <= XBC_IDLE;
            cnt_r <= '0;
        end else if (CE) begin
            // Phase counters reload on entry, so a zero field still lasts one period
            case (state_r)
                XBC_IDLE: begin
                    if (take) begin
                        state_r <= XBC_ADDR;
                        cnt_r <= tc_sel[TC_ALE_LSB +: XBC_WAIT_W];
                    end
                end
                XBC_ADDR: begin
                    if (ref_rise) begin
                        if (cnt_r == '0) begin
                            state_r <= XBC_WAIT;
                            cnt_r <= tc_r[TC_WAIT_LSB +: XBC_WAIT_W];
                        end else begin
                            cnt_r <= cnt_r - 1'b1;
                        end
                    end
                end
                XBC_WAIT: begin
                    if (ref_rise) begin
                        if (cnt_r == '0) begin
                            state_r <= XBC_READY;
                        end else begin
                            cnt_r <= cnt_r - 1'b1;
                        end
                    end
                end
                XBC_READY: begin
                    // Onchip targets answer within the programmed wait, no ready pin
                    if (ref_rise && (onchip_r || !fc_r[FC_RDY_EN_BIT] || ready_act)) begin
                        state_r <= XBC_DONE;
                    end
                end
                XBC_DONE: begin
                    if (ref_rise) begin
                        state_r <= XBC_IDLE;
                    end
                end
                default: begin
                    state_r <= XBC_IDLE;
                end
            endcase
        end
    end

    // Extension bus accesses leave strobes, selects and pin enables quiet; ONCHIP_SEL flags them
    logic active;
    logic mux;
    logic wide;
    assign active = state_r != XBC_IDLE && !onchip_r;
    assign mux = fc_r[FC_MUX_BIT];
    assign wide = fc_r[FC_WIDE_BIT];
    assign ONCHIP_SEL = state_r != XBC_IDLE && onchip_r;
    assign BUSY = state_r != XBC_IDLE;

    // Address pins with width limit and segment line release
    logic [ADDR_W-1:0] amask;
    always_comb begin
        amask = '0;
        for (int i = 0; i < ADDR_W; i++) begin
            if (i < ADDR_BITS) amask[i] = 1'b1;
            if (i >= 16 && i >= 16 + SEG_LINES) amask[i] = 1'b0;
        end
        if (mux) amask[15:0] = '0;
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ADDR_OUT <= '0;
            ADDR_OE_B <= '1;
            AD_OUT <= '0;
            AD_OE_B <= '1;
            ALE <= 1'b0;
            RD_B <= 1'b1;
            WR_B <= 1'b1;
            BHE_B <= 1'b1;
            CS_B <= '1;
        end else if (ref_rise) begin
            ADDR_OUT <= addr_r & amask;
            ADDR_OE_B <= active ? ~amask : '1;
            ALE <= active && state_r == XBC_ADDR;
            RD_B <= !(active && !write_r && strobe_phase(state_r));
            WR_B <= !(active && write_r && strobe_phase(state_r));
            BHE_B <= !(active && wide && (word_r || addr_r[0]));
            CS_B <= '1;
            // Window 4 has no select pin of its own
            if (active && fc_r[FC_CS_EN_BIT] && region_r != 3'd4)
                CS_B[region_r[1:0]] <= 1'b0;
            if (active && mux && state_r == XBC_ADDR) begin
                AD_OUT <= addr_r[15:0];
                AD_OE_B <= '0;
            end else if (active && write_r && state_r != XBC_ADDR) begin
                AD_OUT <= wdata_r;
                AD_OE_B <= wide ? 16'h0000 : 16'hFF00;
            end else begin
                AD_OE_B <= '1;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            RESP_VALID <= 1'b0;
            RESP_RDATA <= '0;
        end else if (CE) begin
            RESP_VALID <= state_r == XBC_DONE && ref_rise;
            // Read data stands until the next read samples the pins in its ready phase
            if (state_r == XBC_READY && ref_rise && !write_r)
                RESP_RDATA <= wide ? ad_sync_r : {8'h00, ad_sync_r[7:0]};
        end
    end
endmodule
`default_nettype wire

/* dv/xbc_chk.sv */
// Pin-level assertions for the external bus controller
`timescale 1ns/10ps
`default_nettype none
module xbc_chk
    import xbc_pkg::*;
#(
    parameter int ADDR_W = XBC_ADDR_W
) (
    input wire logic              CLK,
    input wire logic              RST_B,
    input wire logic              CE,
    input wire logic              SINGLE_CHIP,
    input wire logic [4:0]        ADDR_BITS,
    input wire logic [3:0]        SEG_LINES,
    input wire logic              REQ_READY,
    input wire logic              BUS_REFERENCE_CLOCK_OUT,
    input wire logic [ADDR_W-1:0] ADDR_OE_B,
    input wire logic              ALE,
    input wire logic              RD_B,
    input wire logic              WR_B,
    input wire logic [3:0]        CS_B,
    input wire logic              ONCHIP_SEL
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    sc_quiet_a: assert property (SINGLE_CHIP |-> !REQ_READY)
        else $error("request open in single chip mode");
    addr_width_a: assert property ((~ADDR_OE_B >> ADDR_BITS) == '0)
        else $error("address bit driven above width");
    seg_free_a: assert property ((~ADDR_OE_B[23:16] >> SEG_LINES) == 8'h00)
        else $error("unused segment line driven");
    ale_apart_a: assert property (ALE |-> RD_B && WR_B)
        else $error("strobe during address phase");
    cs_single_a: assert property ($onehot0(~CS_B))
        else $error("two chip selects low");
    ref_toggle_a: assert property (CE |=> BUS_REFERENCE_CLOCK_OUT != $past(BUS_REFERENCE_CLOCK_OUT))
        else $error("reference clock stalled");
    pin_edge_a: assert property ($changed({ALE, RD_B, WR_B, CS_B}) |-> $rose(BUS_REFERENCE_CLOCK_OUT))
        else $error("bus pin moved off reference edge");
    onchip_quiet_a: assert property (ONCHIP_SEL |-> RD_B && WR_B && CS_B == 4'hF)
        else $error("pins active on extension access");
    cover property (!CS_B[3]);
    cover property (!RD_B && !CS_B[2]);
    cover property (ONCHIP_SEL);
endmodule
bind xbc_top xbc_chk #(.ADDR_W(ADDR_W)) xbc_chk_i (.*);
`default_nettype wire

/* dv/xbc_mem.sv */
// External memory model with a slow ready
`timescale 1ns/10ps
`default_nettype none
module xbc_mem (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [23:0] addr_out,
    input  wire logic [15:0] ad_out,
    input  wire logic [15:0] ad_oe_b,
    input  wire logic        ale,
    input  wire logic        rd_b,
    input  wire logic        wr_b,
    input  wire logic        bhe_b,
    input  wire logic        rdy_pol,
    input  wire logic [7:0]  rdy_lat,
    output logic [15:0]      ad_in,
    output logic             ready_in
);
    logic [7:0] mem_r [256];
    logic [7:0] a_r;
    logic [7:0] cnt_r;
    always_ff @(posedge clk) begin
        if (ale) begin
            a_r <= (&ad_oe_b) ? addr_out[7:0] : ad_out[7:0];
        end
    end
    always_ff @(posedge clk) begin
        if (!wr_b) begin
            mem_r[a_r] <= ad_out[7:0];
            if (!bhe_b && !a_r[0]) begin
                mem_r[a_r | 8'h01] <= ad_out[15:8];
            end
        end
    end
    // Released bus flips each cycle so stale data never passes as valid
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ad_in <= 16'hA5A5;
            cnt_r <= 8'h00;
        end else begin
            ad_in <= !rd_b ? {mem_r[a_r | 8'h01], mem_r[a_r]} : ~ad_in;
            cnt_r <= (rd_b && wr_b) ? 8'h00 : cnt_r + {7'h00, cnt_r != 8'hFF};
        end
    end
    assign ready_in = (cnt_r >= rdy_lat) ? rdy_pol : !rdy_pol;
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the external bus controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import xbc_pkg::*;
    logic CLK = 1'b0, RST_B = 1'b0, CE = 1'b1, SINGLE_CHIP = 1'b0, READY_ACT_HIGH = 1'b1;
    logic REQ = 1'b0, REQ_WRITE = 1'b0, REQ_WORD = 1'b1, REQ_ONCHIP = 1'b0, got;
    logic [4:0] ADDR_BITS = 5'h18, wd = 5'h1B;
    logic [3:0] SEG_LINES = 4'h8, DEFAULT_REGION_FUNCTION_CONFIG = 4'hE, CS_B, cs_and;
    logic [7:0] DEFAULT_REGION_TIMING_CONFIG = 8'h10, lat = 8'h01;
    logic [31:0] REGION_TIMING_CONFIG = 32'h1010_1010;
    logic [15:0] REGION_FUNCTION_CONFIG = 16'hEFDE, REQ_WDATA = 16'h0000;
    logic [63:0] WINDOW_ADDRESS_SELECT = 64'h1021_1220_1018_1410;
    logic [23:0] REQ_ADDR = 24'h00_0000, ADDR_OUT, ADDR_OE_B, oe_and;
    logic REQ_READY, RESP_VALID, BUS_REFERENCE_CLOCK_OUT, ALE, RD_B, WR_B, BHE_B, ONCHIP_SEL, BUSY, READY_IN;
    logic [15:0] RESP_RDATA, AD_OUT, AD_OE_B, AD_IN, rdata;
    int cyc, base, i, cycles, fail_count, comparisons;
    logic [23:0] ad [5] = '{24'h05_0010, 24'h11_0020, 24'h18_0030, 24'h22_0040, 24'h21_0050};
    logic [15:0] dt [5] = '{16'h1234, 16'h5A3C, 16'h00A5, 16'hC3E1, 16'h0F96};
    logic [3:0] cs [5] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hF};
    xbc_top xbc_top_i (.*);
    xbc_mem xbc_mem_i (.clk(CLK), .rst_b(RST_B), .addr_out(ADDR_OUT), .ad_out(AD_OUT), .ad_oe_b(AD_OE_B),
        .ale(ALE), .rd_b(RD_B), .wr_b(WR_B), .bhe_b(BHE_B), .rdy_pol(READY_ACT_HIGH), .rdy_lat(lat),
        .ad_in(AD_IN), .ready_in(READY_IN));
    always #5 CLK = ~CLK;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One transfer; held until taken, bounded wait for the response
    task automatic acc(input logic w, input logic wo, input logic oc, input logic [23:0] a, input logic [15:0] d);
        REQ = 1'b1;
        REQ_WRITE = w;
        REQ_WORD = wo;
        REQ_ONCHIP = oc;
        REQ_ADDR = a;
        REQ_WDATA = d;
        cs_and = 4'hF;
        oe_and = 24'hFF_FFFF;
        do @(negedge CLK); while (REQ_READY !== 1'b1);
        @(posedge CLK);
        #1 REQ = 1'b0;
        for (cyc = 0; cyc < 3000 && RESP_VALID !== 1'b1; cyc++) begin
            @(negedge CLK);
            cs_and &= CS_B;
            oe_and &= ADDR_OE_B;
        end
        got = RESP_VALID;
        rdata = RESP_RDATA;
        if (got !== 1'b1) fail_count++;
        @(posedge CLK);
        #1;
    endtask
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            end_of_test;
        end
    end
    initial begin
        repeat (6) @(posedge CLK);
        #1 RST_B = 1'b1;
        chk(CS_B, 4'hF);
        $display("reset test done");
        for (i = 0; i < 5; i++) begin
            acc(1'b1, wd[i], 1'b0, ad[i], dt[i]);
            chk(cs_and, cs[i]);
            acc(1'b0, wd[i], 1'b0, ad[i], 16'h0000);
            chk(rdata, dt[i]);
            chk(cs_and, cs[i]);
        end
        $display("window test done");
        for (i = 0; i < 2; i++) begin
            READY_ACT_HIGH = i[0];
            lat = 8'h28;
            acc(1'b0, 1'b1, 1'b0, ad[1], 16'h0000);
            chk(cyc > 40, 1'b1);
            chk(rdata, dt[1]);
        end
        lat = 8'h01;
        acc(1'b0, 1'b1, 1'b1, ad[0], 16'h0000);
        chk({got, cs_and}, 5'h1F);
        SINGLE_CHIP = 1'b1;
        REQ = 1'b1;
        repeat (10) @(posedge CLK);
        #1 chk({REQ_READY, BUSY}, 2'h0);
        REQ = 1'b0;
        SINGLE_CHIP = 1'b0;
        $display("mode test done");
        ADDR_BITS = 5'h12;
        SEG_LINES = 4'h4;
        @(posedge CLK);
        #1 acc(1'b0, 1'b1, 1'b0, ad[1], 16'h0000);
        base = cyc;
        chk(oe_and, 24'hFC_0000);
        REGION_TIMING_CONFIG[7:0] = 8'h50;
        ADDR_BITS = 5'h14;
        SEG_LINES = 4'h2;
        acc(1'b0, 1'b1, 1'b0, ad[1], 16'h0000);
        chk(cyc >= base + 8, 1'b1);
        chk(oe_and, 24'hFC_0000);
        $display("width test done");
        end_of_test;
    end
endmodule
`default_nettype wire
